// [spva_access.sv]
// Serial program/verify access: mode entry and exit, 20-bit serial frames,
// table pointer, table reads and writes, code region and protection decode.
// Assumes the link clock and pins are asynchronous to clk, the memory read
// data is combinational from mem_raddr, and config inputs are on clk.
//
// Summary of operation
// - HV mode: clock, data low, then enable high
// - Unused I/O go high impedance in mode
// - Mode allows memory read and write serially
// - Low-voltage select works only with enable bit
// - Pointer bytes form 22-bit address
// - Pointer bytes at FF8h, FF7h, FF6h
// - Eight ID bytes readable despite protection
// - Configuration bytes readable despite protection
// - Device ID bytes readable despite protection
// - 8K: two 4K blocks, 512-byte boot
// - 16K: two 8K blocks, 2K boot
// - 32K: four 8K blocks, boot block
// - 64K: four 16K blocks, boot block
// - Each block, boot included, protected separately
// - Drive on rise, sample on fall, LSb first
// - Frame: 4-bit command, 16-bit operand
// - LV mode: select high, then enable high
`timescale 1ns/100ps
module spva_access import spva_pkg::*; #(
  parameter int MEM_KB = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Programming pins
  input wire logic programming_enable_pin,
  input wire logic high_voltage_entry_level,
  input wire logic low_voltage_select_input,
  input wire logic serial_program_clock,
  input wire logic serial_program_data_in,
  output logic serial_program_data_out,
  output logic serial_program_data_oe_n,
  // Configuration
  input wire logic single_supply_enable_bit,
  input wire logic [4:0] code_protect,
  // Status
  output logic prog_mode_active,
  output logic low_voltage_mode,
  output logic unused_io_hiz,
  // Memory port
  output logic [21:0] mem_raddr,
  input wire logic [7:0] mem_rdata,
  output logic [21:0] mem_waddr,
  output logic [15:0] mem_wdata,
  output logic mem_wr,
  output logic mem_prog,
  output logic [3:0] mem_region
);
  localparam logic [21:0] CODE_TOP = 22'(MEM_KB * 1024);
  localparam logic [21:0] BOOT_TOP = (MEM_KB == 8) ? BOOT_TOP_8K
                                                   : BOOT_TOP_LARGE;
  localparam int BLK_SHIFT = (MEM_KB == 8) ? BLK_SHIFT_8K :
                             (MEM_KB == 16) ? BLK_SHIFT_16K :
                             (MEM_KB == 32) ? BLK_SHIFT_32K : BLK_SHIFT_64K;

  spva_state_s s_q;
  spva_state_s s_d;
  logic [4:0] pins;
  logic pe_s, hv_s, lv_s, clk_s, dat_s;
  logic rise, fall, exit_cond;
  logic [3:0] cmd_full;
  logic [15:0] op_full;
  logic [11:0] ram_addr;

  // Code region per size variant; boot block stands apart from block 0
  function automatic spva_region_e region_of(input logic [21:0] a);
    logic [21:0] idx;
    idx = a >> BLK_SHIFT;
    if (a >= ID_FIRST && a <= ID_LAST) begin
      region_of = RGN_ID;
    end else if (a >= CFG_FIRST && a <= CFG_LAST) begin
      region_of = RGN_CFG;
    end else if (a >= DEVID_FIRST) begin
      region_of = RGN_DEVID;
    end else if (a >= CODE_TOP) begin
      region_of = RGN_OTHER;
    end else if (a < BOOT_TOP) begin
      region_of = RGN_BOOT;
    end else begin
      region_of = spva_region_e'(4'(idx[1:0]) + 4'h1);
    end
  endfunction : region_of

  // Protected code blocks read as zero; ID, config and device ID never do
  function automatic logic [7:0] visible(input logic [21:0] a,
                                         input logic [7:0] d);
    spva_region_e r;
    r = region_of(a);
    if (r <= RGN_BLK3 && code_protect[3'(r)]) begin
      visible = PROTECTED_READ;
    end else begin
      visible = d;
    end
  endfunction : visible

  spva_sync #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({programming_enable_pin, high_voltage_entry_level,
               low_voltage_select_input, serial_program_clock,
               serial_program_data_in}),
    .sync_out(pins)
  );

  assign {pe_s, hv_s, lv_s, clk_s, dat_s} = pins;
  assign rise = clk_s && !s_q.clk_prev;
  assign fall = !clk_s && s_q.clk_prev;
  assign cmd_full = {dat_s, s_q.cmd[3:1]};
  assign op_full = {dat_s, s_q.shreg[15:1]};
  assign ram_addr = {RAM_ACCESS_PAGE, op_full[7:0]};
  assign exit_cond = ((s_q.mode == SPVA_HV) ? !hv_s : !pe_s)
                     && !clk_s && !dat_s;

  always_comb begin
    s_d = s_q;
    s_d.mem_wr = 1'b0;
    s_d.mem_prog = 1'b0;
    s_d.clk_prev = clk_s;
    s_d.pe_prev = pe_s;
    s_d.hv_prev = hv_s;
    case (s_q.mode)
      SPVA_OFF: begin
        s_d.bitcnt = '0;
        s_d.pgd_oe_n = 1'b1;
        if (hv_s && !s_q.hv_prev && !clk_s && !dat_s) begin
          s_d.mode = SPVA_HV;
        end else if (pe_s && !s_q.pe_prev && lv_s && !clk_s && !dat_s
                     && single_supply_enable_bit) begin
          s_d.mode = SPVA_LV;
        end
      end
      SPVA_HV, SPVA_LV: begin
        if (exit_cond) begin
          s_d.mode = SPVA_OFF;
          s_d.bitcnt = '0;
          s_d.pgd_oe_n = 1'b1;
        end else begin
          // Output bits go out on rising edges, LSb first
          if (rise && !s_q.pgd_oe_n) begin
            s_d.pgd_out = s_q.latch[0];
            // Rotate so eight rises leave the latched byte for a re-shift
            s_d.latch = {s_q.latch[0], s_q.latch[7:1]};
          end
          if (fall) begin
            s_d.bitcnt = 5'(s_q.bitcnt + BIT_STEP);
            if (s_q.bitcnt < CMD_BITS) begin
              s_d.cmd = cmd_full;
            end else begin
              s_d.shreg = op_full;
            end
            if (s_q.bitcnt == CMD_BITS - BIT_STEP
                && cmd_full == CMD_RD_PREINC) begin
              s_d.tblptr = 22'(s_q.tblptr + PTR_STEP1);
            end
            // Table read: latch the byte before the output half
            if (s_q.bitcnt == OUT_FIRST_BIT - BIT_STEP) begin
              if (s_q.cmd == CMD_SHIFT_LATCH) begin
                s_d.pgd_oe_n = 1'b0;
              end else if (s_q.cmd[3:2] == CMD_RD[3:2]) begin
                s_d.pgd_oe_n = 1'b0;
                s_d.latch = visible(s_q.tblptr, mem_rdata);
                if (s_q.cmd == CMD_RD_POSTINC) begin
                  s_d.tblptr = 22'(s_q.tblptr + PTR_STEP1);
                end else if (s_q.cmd == CMD_RD_POSTDEC) begin
                  s_d.tblptr = 22'(s_q.tblptr - PTR_STEP1);
                end
              end
            end
            if (s_q.bitcnt == FRAME_BITS - BIT_STEP) begin
              s_d.bitcnt = '0;
              s_d.pgd_oe_n = 1'b1;
              if (s_q.cmd == CMD_CORE) begin
                if (op_full[15:8] == OP_LOAD_W) begin
                  s_d.wreg = op_full[7:0];
                end else if (op_full[15:9] == OP_STORE_W && !op_full[8]
                             && op_full[7:0] >= ACCESS_SFR_FIRST) begin
                  case (ram_addr)
                    ADDR_TBL_LOW: s_d.tblptr[7:0] = s_q.wreg;
                    ADDR_TBL_HIGH: s_d.tblptr[15:8] = s_q.wreg;
                    ADDR_TBL_UPPER: s_d.tblptr[21:16] = s_q.wreg[5:0];
                    default: s_d.tblptr = s_q.tblptr;
                  endcase
                end
              end else if (s_q.cmd[3:2] == CMD_WR[3:2]) begin
                s_d.mem_wr = 1'b1;
                s_d.waddr = s_q.tblptr;
                s_d.wdata = op_full;
                s_d.mem_prog = s_q.cmd[1];
                if (s_q.cmd == CMD_WR_INC2 || s_q.cmd == CMD_WR_PROG_INC2) begin
                  s_d.tblptr = 22'(s_q.tblptr + PTR_STEP2);
                end
              end
            end
          end
        end
      end
      default: s_d.mode = SPVA_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{mode: SPVA_OFF, pgd_oe_n: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_program_data_out = s_q.pgd_out;
  assign serial_program_data_oe_n = s_q.pgd_oe_n;
  assign prog_mode_active = (s_q.mode != SPVA_OFF);
  assign low_voltage_mode = (s_q.mode == SPVA_LV);
  assign unused_io_hiz = (s_q.mode != SPVA_OFF);
  assign mem_raddr = s_q.tblptr;
  assign mem_waddr = s_q.waddr;
  assign mem_wdata = s_q.wdata;
  assign mem_wr = s_q.mem_wr;
  assign mem_prog = s_q.mem_prog;
  assign mem_region = region_of(s_q.tblptr);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  hv_entry_a: assert property (
    s_q.mode == SPVA_OFF && hv_s && !s_q.hv_prev && !clk_s && !dat_s
    |=> s_q.mode == SPVA_HV)
    else $error("high-voltage entry not taken");
  lv_gate_a: assert property (
    !single_supply_enable_bit && s_q.mode == SPVA_OFF
    |=> s_q.mode != SPVA_LV)
    else $error("low-voltage mode without enable bit");
  hiz_follow_a: assert property (
    $rose(prog_mode_active) |-> unused_io_hiz ##1 unused_io_hiz
    || !prog_mode_active)
    else $error("unused pins not high impedance in mode");
  exit_off_a: assert property (
    s_q.mode != SPVA_OFF && exit_cond |=> !prog_mode_active)
    else $error("mode not left on enable drop");
  frame_end_a: assert property (
    mem_wr |-> s_q.bitcnt == 5'h00 && $past(fall) && $past(s_q.bitcnt)
    == FRAME_BITS - BIT_STEP)
    else $error("write not at end of 20-bit frame");
  drive_rise_a: assert property (
    $changed(serial_program_data_out) |-> $past(rise))
    else $error("data changed outside a rising edge");
  off_quiet_a: assert property (
    s_q.mode == SPVA_OFF |=> !mem_wr && serial_program_data_oe_n)
    else $error("access outside program mode");
  id_read_a: assert property (
    mem_region == RGN_ID |-> visible(mem_raddr, mem_rdata) == mem_rdata)
    else $error("ID byte masked by protection");
  cfg_read_a: assert property (
    mem_region == RGN_CFG |-> visible(mem_raddr, mem_rdata) == mem_rdata)
    else $error("config byte masked by protection");
  devid_read_a: assert property (
    mem_region == RGN_DEVID |-> visible(mem_raddr, mem_rdata) == mem_rdata)
    else $error("device ID masked by protection");
  boot_rgn_a: assert property (
    mem_raddr < BOOT_TOP |-> mem_region == RGN_BOOT)
    else $error("boot block not decoded apart");
  ptr_hold_a: assert property (
    !fall |=> $stable(mem_raddr))
    else $error("pointer moved without a link edge");
  boot_prot_a: assert property (
    mem_region == RGN_BOOT && code_protect[0]
    |-> visible(mem_raddr, mem_rdata) == PROTECTED_READ)
    else $error("protected boot byte readable");
  out_window_a: assert property (
    s_q.bitcnt < OUT_FIRST_BIT |-> serial_program_data_oe_n)
    else $error("data driven before operand output half");

  hv_entry_c: cover property (s_q.mode == SPVA_OFF ##1 s_q.mode == SPVA_HV);
  lv_entry_c: cover property (s_q.mode == SPVA_OFF ##1 s_q.mode == SPVA_LV);
  tbl_write_c: cover property (mem_wr && mem_prog);
  tbl_read_c: cover property ($fell(serial_program_data_oe_n));
  rd_dec_c: cover property (fall && s_q.cmd == CMD_RD_POSTDEC
    && s_q.bitcnt == OUT_FIRST_BIT - BIT_STEP);
endmodule : spva_access

// [spva_access_tb_top.sv]
// Self-checking bench for spva_access: programmer model on the link,
// formula memory on the read port, queued write and read expectations.
// Assumes the 64-Kbyte variant and a 50 MHz core clock.
`timescale 1ns/100ps
module spva_access_tb_top import spva_pkg::*;;
  typedef struct packed {
    logic [21:0] a;
    logic [15:0] d;
    logic p;
  } spva_wexp_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ss_en = 1'b0;
  logic [4:0] cprot = 5'h00;
  logic pe, hv, sel, lclk, dd, dw, dout, oe_n, mact, lvm, hiz, wr, prog, rstb;
  logic [21:0] raddr, waddr, ptr;
  logic [15:0] wdata;
  logic [7:0] rdata, rbyte, lat;
  logic [3:0] rgn;
  spva_wexp_s eq[$];
  spva_wexp_s e;
  logic [7:0] rq[$];
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 30428;
  logic [21:0] tbl [11] = '{22'h0007FF, 22'h000800, 22'h003FFF,
    22'h004000, 22'h00FFFF, 22'h010000, 22'h200007, 22'h200008,
    22'h30000D, 22'h30000E, 22'h3FFFFE};
  logic [21:0] pa [6] = '{22'h0007FF, 22'h000800, 22'h00C000,
    22'h200007, 22'h30000D, 22'h3FFFFE};
  logic [3:0] rc [5] = '{CMD_RD, CMD_RD_POSTINC, CMD_RD_POSTDEC,
    CMD_RD_PREINC, CMD_SHIFT_LATCH};

  always #10 clk = ~clk;
  // Device drives the data wire while its enable is low
  assign dw = oe_n ? dd : dout;
  assign rdata = raddr[7:0] ^ raddr[15:8] ^ {2'b00, raddr[21:16]};

  spva_prog_model u_prog (.clk(clk), .pe(pe), .hv(hv), .sel(sel),
    .lclk(lclk), .dd(dd), .dw(dw), .rd_stb(rstb), .rd_byte(rbyte));

  spva_access #(.MEM_KB(64)) u_dut (.clk(clk), .rst_n(rst_n),
    .programming_enable_pin(pe), .high_voltage_entry_level(hv),
    .low_voltage_select_input(sel), .serial_program_clock(lclk),
    .serial_program_data_in(dw), .serial_program_data_out(dout),
    .serial_program_data_oe_n(oe_n), .single_supply_enable_bit(ss_en),
    .code_protect(cprot), .prog_mode_active(mact),
    .low_voltage_mode(lvm), .unused_io_hiz(hiz), .mem_raddr(raddr),
    .mem_rdata(rdata), .mem_waddr(waddr), .mem_wdata(wdata),
    .mem_wr(wr), .mem_prog(prog), .mem_region(rgn));

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, x, g);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  function automatic logic [3:0] reg_of(input logic [21:0] a);
    if (a < 22'h000800) return RGN_BOOT;
    if (a < 22'h010000) return RGN_BLK0 + {2'b00, a[15:14]};
    if (a >= ID_FIRST && a <= ID_LAST) return RGN_ID;
    if (a >= CFG_FIRST && a <= CFG_LAST) return RGN_CFG;
    if (a >= DEVID_FIRST) return RGN_DEVID;
    return RGN_OTHER;
  endfunction : reg_of

  function automatic logic [7:0] exp_byte(input logic [21:0] a);
    logic [3:0] r;
    r = reg_of(a);
    if (r < RGN_ID && cprot[r[2:0]]) return 8'h00;
    return a[7:0] ^ a[15:8] ^ {2'b00, a[21:16]};
  endfunction : exp_byte

  task automatic wait_mode(input logic m, input logic l);
    int k;
    k = 0;
    while (mact !== m && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk("mode", m, mact);
    chk("unused io hiz", m, hiz);
    chk("lv mode", l, lvm);
    if (k >= 20) final_report;
  endtask : wait_mode

  task automatic load(input logic [21:0] a);
    logic [23:0] v;
    v = {2'b00, a};
    for (int i = 0; i < 3; i++) begin
      u_prog.frame(CMD_CORE, {OP_LOAD_W, v[23-8*i -: 8]});
      u_prog.frame(CMD_CORE, {OP_STORE_W, 1'b0,
        ADDR_TBL_UPPER[7:0] - 8'(i)});
    end
    ptr = a;
    repeat (2) @(posedge clk);
    chk("pointer", ptr, raddr);
  endtask : load

  task automatic wr_op(input logic [3:0] c);
    logic [15:0] d;
    d = 16'($random(seed));
    eq.push_back({ptr, d, c[3:1] == 3'b111});
    u_prog.frame(c, d);
    if (c == CMD_WR_INC2 || c == CMD_WR_PROG_INC2) ptr = ptr + 22'h000002;
    chk("pointer", ptr, raddr);
  endtask : wr_op

  task automatic rd_op(input logic [3:0] c);
    if (c == CMD_RD_PREINC) ptr = ptr + 22'h000001;
    if (c != CMD_SHIFT_LATCH) lat = exp_byte(ptr);
    rq.push_back(lat);
    u_prog.frame(c, 16'($random(seed)));
    if (c == CMD_RD_POSTINC) ptr = ptr + 22'h000001;
    if (c == CMD_RD_POSTDEC) ptr = ptr - 22'h000001;
    chk("pointer", ptr, raddr);
  endtask : rd_op

  always @(posedge clk) begin
    if (wr === 1'b1) begin
      if (eq.size() == 0) chk("write count", 0, 1);
      else begin
        e = eq.pop_front();
        chk("write addr", e.a, waddr);
        chk("write data", e.d, wdata);
        chk("start prog", e.p, prog);
      end
    end
    if (rstb === 1'b1) begin
      if (rq.size() == 0) chk("read count", 0, 1);
      else chk("read byte", rq.pop_front(), rbyte);
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    chk("timeout", 0, 1);
    final_report;
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("reset ptr", 0, raddr);
    chk("reset region", RGN_BOOT, rgn);
    repeat (4) @(posedge clk);
    u_prog.enter(1'b0, 1'b1);
    repeat (10) @(posedge clk);
    wait_mode(1'b0, 1'b0);
    u_prog.leave();
    u_prog.enter(1'b1, 1'b0);
    repeat (10) @(posedge clk);
    wait_mode(1'b0, 1'b0);
    u_prog.leave();
    ss_en <= 1'b1;
    u_prog.enter(1'b1, 1'b0);
    wait_mode(1'b1, 1'b1);
    load(22'h00ABCD);
    u_prog.leave();
    wait_mode(1'b0, 1'b0);
    u_prog.enter(1'b0, 1'b0);
    wait_mode(1'b1, 1'b0);
    foreach (tbl[i]) begin
      load(tbl[i]);
      chk("region", reg_of(tbl[i]), rgn);
    end
    u_prog.frame(CMD_CORE, {OP_STORE_W, 1'b0, 8'hF9});
    repeat (2) @(posedge clk);
    chk("ignored store", ptr, raddr);
    // Program code, then verify, configuration last
    load(22'h000800);
    for (int i = 0; i < 4; i++) wr_op(CMD_WR + 4'(i));
    load(22'h000800);
    foreach (rc[i]) rd_op(rc[i]);
    cprot <= 5'h1F;
    foreach (pa[i]) begin
      load(pa[i]);
      rd_op(CMD_RD_POSTINC);
    end
    cprot <= 5'h02;
    load(22'h0007FF);
    rd_op(CMD_RD_POSTINC);
    rd_op(CMD_RD);
    load(CFG_FIRST);
    wr_op(CMD_WR);
    u_prog.leave();
    wait_mode(1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("pending writes", 0, eq.size());
    chk("pending reads", 0, rq.size());
    final_report;
  end
endmodule : spva_access_tb_top

// [spva_pkg.sv]
// Package for the serial program/verify access block: pointer register
// addresses, address regions, command codes, link framing and state types.
// Assumes a single 50 MHz core clock domain for everything that imports it.
package spva_pkg;

  // Table pointer byte registers in data RAM space
  localparam logic [11:0] ADDR_TBL_LOW = 12'hFF6;
  localparam logic [11:0] ADDR_TBL_HIGH = 12'hFF7;
  localparam logic [11:0] ADDR_TBL_UPPER = 12'hFF8;
  localparam logic [3:0] RAM_ACCESS_PAGE = 4'hF;
  localparam logic [7:0] ACCESS_SFR_FIRST = 8'h60;

  // Configuration and ID space
  localparam logic [21:0] ID_FIRST = 22'h200000;
  localparam logic [21:0] ID_LAST = 22'h200007;
  localparam logic [21:0] CFG_FIRST = 22'h300000;
  localparam logic [21:0] CFG_LAST = 22'h30000D;
  localparam logic [21:0] DEVID_FIRST = 22'h3FFFFE;
  localparam logic [21:0] DEVID_LAST = 22'h3FFFFF;

  // Code memory layout per size variant
  localparam logic [21:0] BOOT_TOP_8K = 22'h000200;
  localparam logic [21:0] BOOT_TOP_LARGE = 22'h000800;
  localparam int BLK_SHIFT_8K = 12;
  localparam int BLK_SHIFT_16K = 13;
  localparam int BLK_SHIFT_32K = 13;
  localparam int BLK_SHIFT_64K = 14;
  localparam logic [7:0] PROTECTED_READ = 8'h00;

  // Serial framing
  localparam logic [4:0] CMD_BITS = 5'h04;
  localparam logic [4:0] OUT_FIRST_BIT = 5'h0C;
  localparam logic [4:0] FRAME_BITS = 5'h14;
  localparam logic [4:0] BIT_STEP = 5'h01;
  localparam logic [21:0] PTR_STEP1 = 22'h000001;
  localparam logic [21:0] PTR_STEP2 = 22'h000002;

  // Four-bit commands
  localparam logic [3:0] CMD_CORE = 4'h0;
  localparam logic [3:0] CMD_SHIFT_LATCH = 4'h2;
  localparam logic [3:0] CMD_RD = 4'h8;
  localparam logic [3:0] CMD_RD_POSTINC = 4'h9;
  localparam logic [3:0] CMD_RD_POSTDEC = 4'hA;
  localparam logic [3:0] CMD_RD_PREINC = 4'hB;
  localparam logic [3:0] CMD_WR = 4'hC;
  localparam logic [3:0] CMD_WR_INC2 = 4'hD;
  localparam logic [3:0] CMD_WR_PROG_INC2 = 4'hE;
  localparam logic [3:0] CMD_WR_PROG = 4'hF;

  // Core instruction opcodes understood here
  localparam logic [7:0] OP_LOAD_W = 8'h0E;
  localparam logic [6:0] OP_STORE_W = 7'h37;

  typedef enum logic [1:0] {
    SPVA_OFF = 2'b00,
    SPVA_HV = 2'b01,
    SPVA_LV = 2'b10
  } spva_mode_e;

  typedef enum logic [3:0] {
    RGN_BOOT = 4'h0,
    RGN_BLK0 = 4'h1,
    RGN_BLK1 = 4'h2,
    RGN_BLK2 = 4'h3,
    RGN_BLK3 = 4'h4,
    RGN_ID = 4'h5,
    RGN_CFG = 4'h6,
    RGN_DEVID = 4'h7,
    RGN_OTHER = 4'h8
  } spva_region_e;

  typedef struct packed {
    spva_mode_e mode;
    logic clk_prev;
    logic pe_prev;
    logic hv_prev;
    logic [4:0] bitcnt;
    logic [3:0] cmd;
    logic [15:0] shreg;
    logic [21:0] tblptr;
    logic [7:0] wreg;
    logic [7:0] latch;
    logic pgd_out;
    logic pgd_oe_n;
    logic mem_wr;
    logic mem_prog;
    logic [21:0] waddr;
    logic [15:0] wdata;
  } spva_state_s;

endpackage : spva_pkg

// [spva_prog_model.sv]
// Programmer model: drives the enable, select, link clock and data pins.
// Assumes clk at 20 ns; the link clock half period is four clk cycles.
`timescale 1ns/100ps
module spva_prog_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic pe,
  output logic hv,
  output logic sel,
  output logic lclk,
  output logic dd,
  input wire logic dw,
  // Read result
  output logic rd_stb,
  output logic [7:0] rd_byte
);
  initial begin
    pe = 1'b0;
    hv = 1'b0;
    sel = 1'b0;
    lclk = 1'b0;
    dd = 1'b0;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
  end

  // Clock and data held, then the enable level rises
  task automatic enter(input logic lv, input logic ck);
    @(posedge clk);
    lclk <= ck;
    dd <= 1'b0;
    sel <= lv;
    repeat (4) @(posedge clk);
    pe <= 1'b1;
    hv <= !lv;
  endtask : enter

  task automatic leave;
    @(posedge clk);
    lclk <= 1'b0;
    pe <= 1'b0;
    hv <= 1'b0;
    repeat (4) @(posedge clk);
    sel <= 1'b0;
  endtask : leave

  // Released slots of read frames toggle so a stale level never passes
  task automatic frame(input logic [3:0] cmd, input logic [15:0] op);
    logic [19:0] b;
    logic rd;
    logic [7:0] got;
    b = {op, cmd};
    rd = cmd[3:2] == 2'b10 || cmd == 4'h2;
    got = 8'h00;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      lclk <= 1'b1;
      dd <= (rd && i >= 12) ? !dd : b[i];
      repeat (4) @(posedge clk);
      lclk <= 1'b0;
      #1;
      if (rd && i >= 12) got[i-12] = dw;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    dd <= 1'b0;
    rd_byte <= got;
    rd_stb <= rd;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : frame
endmodule : spva_prog_model

// [spva_sync.sv]
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes inputs are independent levels; no bus coherence is implied.
`timescale 1ns/100ps
module spva_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } spva_sync_s;

  spva_sync_s s_q;
  spva_sync_s s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.s2;
endmodule : spva_sync
